// *** sec_pkg.sv ***
// shared constants for the serial eeprom command engine
package sec_pkg;
	localparam int          ADDR_W_DEF   = 8;
	localparam int          DATA_W_DEF   = 16;
	localparam int          CLK_MHZ      = 100;
	localparam int          PROG_TIME_US = 4000;
	localparam int          PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
	localparam logic [1:0]  OP_SPECIAL   = 2'h0;
	localparam logic [1:0]  OP_WRITE     = 2'h1;
	localparam logic [1:0]  OP_READ      = 2'h2;
	localparam logic [1:0]  OP_ERASE     = 2'h3;
	localparam logic [1:0]  SUB_DISABLE  = 2'h0;
	localparam logic [1:0]  SUB_FILL     = 2'h1;
	localparam logic [1:0]  SUB_CLEAR    = 2'h2;
	localparam logic [1:0]  SUB_ENABLE   = 2'h3;
	localparam logic        WEN_RESET    = 1'b0;
	localparam int          FIFO_DEPTH_DEF = 4;

	typedef enum logic [2:0] {
		SEC_IDLE  = 3'b000,
		SEC_SHIFT = 3'b001,
		SEC_READ  = 3'b010,
		SEC_ARMED = 3'b011,
		SEC_PROG  = 3'b100
	} sec_state_t;
endpackage : sec_pkg

// *** sec_stream_if.sv ***
// valid/ready word stream between engine and fifo
`timescale 1ns/100ps
`default_nettype none
interface sec_stream_if #(parameter int W = 16);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface : sec_stream_if
`default_nettype wire

// *** sec_fifo.sv ***
// small word fifo between array read port and serialiser
`timescale 1ns/100ps
`default_nettype none
module sec_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 4
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic flush_i,
	sec_stream_if.dst in_s,
	sec_stream_if.src out_s
);
	localparam int PW = $clog2(DEPTH);
	// refuse depths the pointer wrap cannot serve
	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("sec_fifo depth must be a power of two >= 2");
	end
	logic [W-1:0] mem [DEPTH];
	logic [PW:0]  wp, rp, next_wp, next_rp;
	logic         full, empty, push, pop;

	// flags and pointer steps
	always_comb begin
		empty = (wp == rp);
		full  = (wp[PW-1:0] == rp[PW-1:0]) && (wp[PW] != rp[PW]);
		in_s.ready  = !full;
		out_s.valid = !empty;
		out_s.data  = mem[rp[PW-1:0]];
		push = in_s.valid && !full;
		pop  = out_s.ready && !empty;
		next_wp = flush_i ? '0 : wp + (PW+1)'(push);
		next_rp = flush_i ? '0 : rp + (PW+1)'(pop);
	end

	// pointer registers
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp <= '0;
			rp <= '0;
		end else if (ce_i) begin
			wp <= next_wp;
			rp <= next_rp;
		end
	end

	// storage
	always_ff @(posedge sys_clk_i) begin
		if (ce_i && push && !flush_i)
			mem[wp[PW-1:0]] <= in_s.data;
	end
endmodule : sec_fifo
`default_nettype wire

// *** sec_engine.sv ***
// serial eeprom command engine: decode, read stream, self-timed program
`timescale 1ns/100ps
`default_nettype none
// How it works
// - after read and address, drive output, send a zero, then word MSB first.
// - each read bit changes on a rising serial clock edge.
// - continued clocking with select high reads the next word.
// - address counter wraps from last location to zero.
// - leading zero only before the first word of a burst.
// - reset leaves the program enable latch cleared.
// - enable latch holds until disable command or reset.
// - with latch cleared, write and erase commands are ignored.
// - reads work whatever the enable latch says.
// - write starts on select fall: clear then store the word.
// - programming completes with no serial clock edges.
// - write clears the target itself, no erase needed first.
// - select high during programming drives busy status on output.
// - erase clears one location to all ones on select fall.
// - clear-all sets every bit to one on select fall.
// - fill-all writes the word everywhere on select fall.
// - bits sampled on rising clock: start bit, opcode, address, data.
// - status low while busy, high when ready.
// - opcodes read 10, erase 11, write 01, special 00 by top address bits.
module sec_engine
	import sec_pkg::*;
#(
	parameter int ADDR_W     = ADDR_W_DEF,
	parameter int DATA_W     = DATA_W_DEF,
	parameter int PROG_COUNT = PROG_CYCLES
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic chip_select_i,
	input  wire logic serial_clock_pin_i,
	input  wire logic serial_in_pin_i,
	output logic      serial_out_o,
	output logic      serial_out_oe_o,
	output logic      busy_o
);
	localparam int DEPTH  = 1 << ADDR_W;
	localparam int CMD_W  = 3 + ADDR_W;
	localparam int FULL_W = CMD_W + DATA_W;
	localparam int BC_W   = $clog2(FULL_W + 1);
	localparam int BIT_W  = $clog2(DATA_W + 1);
	localparam int TC_W   = $clog2(PROG_COUNT + 1);
	// refuse sizes the command decode cannot serve
	if (ADDR_W < 2 || DATA_W < 1 || PROG_COUNT < 1) begin : g_bad_par
		$error("sec_engine parameters out of range");
	end

	// two-stage synchronisers for the pins
	logic [1:0] cs_sy, sk_sy, di_sy;
	logic       cs_d, sk_d;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_sy <= 2'h0;
			sk_sy <= 2'h0;
			di_sy <= 2'h0;
			cs_d  <= 1'b0;
			sk_d  <= 1'b0;
		end else if (ce_i) begin
			cs_sy <= {cs_sy[0], chip_select_i};
			sk_sy <= {sk_sy[0], serial_clock_pin_i};
			di_sy <= {di_sy[0], serial_in_pin_i};
			cs_d  <= cs_sy[1];
			sk_d  <= sk_sy[1];
		end
	end
	wire cs    = cs_sy[1];
	wire di    = di_sy[1];
	wire sk_up = sk_sy[1] && !sk_d;

	logic [DATA_W-1:0] mem [DEPTH];
	sec_state_t        state, next_state;
	logic [FULL_W-1:0] sh, next_sh;
	logic [BC_W-1:0]   bcnt, next_bcnt;
	logic [ADDR_W-1:0] rd_addr, next_rd_addr;
	logic [DATA_W-1:0] oreg, next_oreg;
	logic [BIT_W-1:0]  obit, next_obit;
	logic              dout, next_dout;
	logic              oe, next_oe;
	logic              wen, next_wen;
	logic              first, next_first;
	logic [1:0]        pop, next_pop;   // 0 none,1 write,2 erase,3 bulk
	logic              bulk_fill, next_bulk_fill;
	logic [ADDR_W-1:0] paddr, next_paddr;
	logic [DATA_W-1:0] pdata, next_pdata;
	logic [TC_W-1:0]   tcnt, next_tcnt;

	sec_stream_if #(.W(DATA_W)) fin ();
	sec_stream_if #(.W(DATA_W)) fout ();
	logic flush;

	sec_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH_DEF)) u_fifo (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.flush_i   (flush),
		.in_s      (fin),
		.out_s     (fout)
	);

	// fifo is prefetched from the array while reading
	always_comb begin
		fin.valid = (state == SEC_READ);
		fin.data  = mem[rd_addr];
		flush     = !cs || state != SEC_READ;
	end

	// decoded command fields from the shift register
	wire [1:0]        op    = sh[ADDR_W +: 2];
	wire [1:0]        sub   = sh[ADDR_W-1 -: 2];
	wire [ADDR_W-1:0] adr   = sh[ADDR_W-1:0];
	wire [DATA_W-1:0] wdata = sh[DATA_W-1:0];
	wire [1:0]        op_w  = sh[DATA_W+ADDR_W +: 2];
	wire [1:0]        sub_w = sh[DATA_W+ADDR_W-1 -: 2];
	wire [ADDR_W-1:0] adr_w = sh[DATA_W +: ADDR_W];

	// next-state logic for the command engine
	always_comb begin
		next_state     = state;
		next_sh        = sh;
		next_bcnt      = bcnt;
		next_rd_addr   = rd_addr;
		next_oreg      = oreg;
		next_obit      = obit;
		next_dout      = dout;
		next_oe        = oe;
		next_wen       = wen;
		next_first     = first;
		next_pop       = pop;
		next_bulk_fill = bulk_fill;
		next_paddr     = paddr;
		next_pdata     = pdata;
		next_tcnt      = tcnt;
		fout.ready     = 1'b0;
		case (state)
			SEC_IDLE: begin
				next_bcnt = '0;
				next_sh   = '0;
				if (cs && sk_up && di) begin
					next_state = SEC_SHIFT;
					next_sh    = FULL_W'(1);
					next_bcnt  = BC_W'(1);
				end
			end
			SEC_SHIFT: begin
				if (!cs) begin
					next_state = SEC_IDLE;
				end else if (sk_up) begin
					next_sh   = {sh[FULL_W-2:0], di};
					next_bcnt = bcnt + BC_W'(1);
					if (bcnt + BC_W'(1) == BC_W'(CMD_W)) begin
						if (sh[ADDR_W -: 2] == OP_READ) begin
							next_rd_addr = {sh[ADDR_W-2:0], di};
							next_state   = SEC_READ;
							next_first   = 1'b1;
							next_oe      = 1'b1;
							next_dout    = 1'b0;
						end
					end
				end else if (bcnt == BC_W'(CMD_W)) begin
					case (op)
						OP_ERASE: begin
							next_state = wen ? SEC_ARMED : SEC_IDLE;
							next_pop   = 2'h2;
							next_paddr = adr;
						end
						OP_SPECIAL: begin
							if (sub == SUB_ENABLE) begin
								next_wen   = 1'b1;
								next_state = SEC_IDLE;
							end else if (sub == SUB_DISABLE) begin
								next_wen   = 1'b0;
								next_state = SEC_IDLE;
							end else if (sub == SUB_CLEAR) begin
								next_state     = wen ? SEC_ARMED : SEC_IDLE;
								next_pop       = 2'h3;
								next_bulk_fill = 1'b0;
							end
						end
						default: ;
					endcase
					if (!wen && (op == OP_ERASE || (op == OP_SPECIAL
					    && sub == SUB_CLEAR)))
						next_state = SEC_IDLE;
				end else if (bcnt == BC_W'(FULL_W)) begin
					if (op_w == OP_WRITE) begin
						next_pop   = 2'h1;
						next_paddr = adr_w;
						next_pdata = wdata;
						next_state = wen ? SEC_ARMED : SEC_IDLE;
					end else if (op_w == OP_SPECIAL && sub_w == SUB_FILL) begin
						next_pop       = 2'h3;
						next_bulk_fill = 1'b1;
						next_pdata     = wdata;
						next_state     = wen ? SEC_ARMED : SEC_IDLE;
					end else begin
						next_state = SEC_IDLE;
					end
				end
			end
			SEC_READ: begin
				if (!cs) begin
					next_state = SEC_IDLE;
					next_oe    = 1'b0;
				end else if (sk_up) begin
					if (first || obit == '0) begin
						fout.ready = 1'b1;
						next_oreg  = fout.data << 1;
						next_dout  = fout.data[DATA_W-1];
						next_obit  = BIT_W'(DATA_W - 1);
						next_first = 1'b0;
					end else begin
						next_dout = oreg[DATA_W-1];
						next_oreg = oreg << 1;
						next_obit = obit - BIT_W'(1);
					end
				end
			end
			SEC_ARMED: begin
				// waits for select fall to start the timed cycle
				if (!cs) begin
					next_state = SEC_PROG;
					next_tcnt  = TC_W'(PROG_COUNT);
				end
			end
			SEC_PROG: begin
				// self-timed, no serial clock needed
				next_tcnt = tcnt - TC_W'(1);
				next_oe   = cs;
				next_dout = 1'b0;
				if (tcnt == TC_W'(1)) begin
					next_state = SEC_IDLE;
					next_pop   = 2'h0;
					next_dout  = 1'b1;
				end
			end
			default: next_state = SEC_IDLE;
		endcase
		// ready status stays on the pin until select falls or a start bit is clocked in
		if (state == SEC_IDLE && !cs)
			next_oe = 1'b0;
		else if (state == SEC_IDLE && oe && cs && sk_up && di)
			next_oe = 1'b0;
		// read address advances as the fifo accepts each word
		if (state == SEC_READ && fin.ready)
			next_rd_addr = rd_addr + ADDR_W'(1);
	end

	// engine registers
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state     <= SEC_IDLE;
			sh        <= '0;
			bcnt      <= '0;
			rd_addr   <= '0;
			oreg      <= '0;
			obit      <= '0;
			dout      <= 1'b0;
			oe        <= 1'b0;
			wen       <= WEN_RESET;
			first     <= 1'b0;
			pop       <= 2'h0;
			bulk_fill <= 1'b0;
			paddr     <= '0;
			pdata     <= '0;
			tcnt      <= '0;
		end else if (ce_i) begin
			state     <= next_state;
			sh        <= next_sh;
			bcnt      <= next_bcnt;
			rd_addr   <= next_rd_addr;
			oreg      <= next_oreg;
			obit      <= next_obit;
			dout      <= next_dout;
			oe        <= next_oe;
			wen       <= next_wen;
			first     <= next_first;
			pop       <= next_pop;
			bulk_fill <= next_bulk_fill;
			paddr     <= next_paddr;
			pdata     <= next_pdata;
			tcnt      <= next_tcnt;
		end
	end

	// array update at the end of the timed cycle
	always_ff @(posedge sys_clk_i) begin
		if (ce_i && state == SEC_PROG && tcnt == TC_W'(1)) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (pop == 2'h3)
					mem[i] <= bulk_fill ? pdata : '1;
			end
			if (pop == 2'h1)
				mem[paddr] <= pdata;
			else if (pop == 2'h2)
				mem[paddr] <= '1;
		end
	end

	always_comb begin
		serial_out_o    = dout;
		serial_out_oe_o = oe;
		busy_o          = (state == SEC_PROG);
	end
endmodule : sec_engine
`default_nettype wire

// *** sec_host.sv ***
// host side model: select, serial clock and data towards the engine
`timescale 1ns/100ps
`default_nettype none
module sec_host (
	output logic      cs_o,
	output logic      sk_o,
	output logic      di_o,
	input  wire logic do_i,
	input  wire logic oe_i
);
	logic last = 1'b0;
	logic do_w;
	// released line shows the inverse of the last driven bit
	always @* if (oe_i) last = do_i;
	assign do_w = oe_i ? do_i : ~last;
	initial begin
		cs_o = 1'b0;
		sk_o = 1'b0;
		di_o = 1'b0;
	end
	// one 80 ns serial clock, data set while low, output read before rise
	task automatic bit_(input logic b, output logic q);
		sk_o = 1'b0;
		di_o = b;
		#38 q = do_w;
		#2 sk_o = 1'b1;
		#40;
	endtask : bit_
	// start bit, opcode, address and optional data, msb first
	task automatic send(input logic [26:0] v, input int n);
		logic q;
		cs_o = 1'b1;
		for (int i = n - 1; i >= 0; i--) bit_(v[i], q);
	endtask : send
	// clock parks low, select held low past its minimum
	task automatic drop();
		sk_o = 1'b0;
		cs_o = 1'b0;
		#300;
	endtask : drop
endmodule : sec_host
`default_nettype wire

// *** sec_asserts.sv ***
// pin level assertions for the command engine
`timescale 1ns/100ps
`default_nettype none
module sec_asserts import sec_pkg::*; #(
	parameter int PROG_COUNT = PROG_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic chip_select_i,
	input wire logic serial_clock_pin_i,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_o,
	input wire logic busy_o
);
	logic [31:0] cnt;
	logic [3:0]  age;
	logic        skq;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// busy length and cycles since the last serial clock rise
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= '0;
			age <= '0;
			skq <= 1'b0;
		end else begin
			cnt <= busy_o ? cnt + 32'h1 : 32'h0;
			age <= (serial_clock_pin_i && !skq) ? 4'h0 :
				(age == 4'hf ? age : age + 4'h1);
			skq <= serial_clock_pin_i;
		end
	end
	sequence s_hold;
		busy_o [*8];
	endsequence
	sequence s_ready;
		##[0:3] serial_out_oe_o && serial_out_o;
	endsequence
	property p_rst_idle;
		$fell(rst_i) |-> !busy_o && !serial_out_oe_o;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("outputs busy after reset");
	property p_dummy;
		$rose(serial_out_oe_o) && !busy_o |-> !serial_out_o;
	endproperty
	a_dummy: assert property (p_dummy)
		else $error("first read bit not zero");
	property p_bit_on_rise;
		serial_out_oe_o && $past(serial_out_oe_o) && $changed(serial_out_o)
		&& !($past(busy_o) | $past(busy_o, 2) | $past(busy_o, 3))
		|-> age < 4'h7;
	endproperty
	a_bit_on_rise: assert property (p_bit_on_rise)
		else $error("output changed without clock rise");
	property p_hiz;
		$fell(chip_select_i) |-> ##[1:6] !serial_out_oe_o;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("output still driven after deselect");
	property p_start_low;
		$rose(busy_o) |-> !chip_select_i;
	endproperty
	a_start_low: assert property (p_start_low)
		else $error("cycle started with select high");
	property p_self_timed;
		$rose(busy_o) |-> s_hold;
	endproperty
	a_self_timed: assert property (p_self_timed)
		else $error("cycle stopped early");
	property p_prog_len;
		$fell(busy_o) |-> cnt >= PROG_COUNT - 1 && cnt <= PROG_COUNT + 1;
	endproperty
	a_prog_len: assert property (p_prog_len)
		else $error("cycle length wrong");
	property p_poll_busy;
		busy_o && serial_out_oe_o |-> !serial_out_o;
	endproperty
	a_poll_busy: assert property (p_poll_busy)
		else $error("status high while busy");
	property p_poll_ready;
		$fell(busy_o) && chip_select_i |-> s_ready;
	endproperty
	a_poll_ready: assert property (p_poll_ready)
		else $error("status not high after cycle");
endmodule : sec_asserts
bind sec_engine sec_asserts #(.PROG_COUNT(PROG_COUNT)) u_sec_asserts (
	.sys_clk_i, .rst_i, .chip_select_i, .serial_clock_pin_i,
	.serial_out_o, .serial_out_oe_o, .busy_o);
`default_nettype wire

// *** tb.sv ***
// testbench for the serial eeprom command engine
`timescale 1ns/100ps
`default_nettype none
module tb
	import sec_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic rst_i     = 1'b1;
	logic cs, sk, di, out, oe, busy;
	int   num_errors = 0;
	int   checked    = 0;
	int   cycles     = 0;
	sec_engine #(.PROG_COUNT(50)) u_sec_engine (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.chip_select_i(cs), .serial_clock_pin_i(sk), .serial_in_pin_i(di),
		.serial_out_o(out), .serial_out_oe_o(oe), .busy_o(busy));
	sec_host u_sec_host (.cs_o(cs), .sk_o(sk), .di_o(di), .do_i(out),
		.oe_i(oe));
	initial forever #5 sys_clk_i = ~sys_clk_i;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	// hang guard
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : wt
	// send a command, deselect, expect run or refusal, poll status
	task automatic prog(input logic [1:0] op, input logic [7:0] a,
		input logic [15:0] d, input logic run);
		logic dat;
		dat = op == OP_WRITE || (op == OP_SPECIAL && a[7:6] == SUB_FILL);
		u_sec_host.send(dat ? {1'b1, op, a, d} : {16'h0, 1'b1, op, a},
			dat ? 27 : 11);
		u_sec_host.drop();
		check(busy, run);
		if (run) begin
			u_sec_host.cs_o = 1'b1;
			wt(6);
			check({oe, out}, 2'b10);
			for (int k = 0; k < 100 && busy; k++) wt(1);
			wt(4);
			check({oe, out}, 2'b11);
			u_sec_host.drop();
		end
	endtask : prog
	// two word read burst: dummy zero, then both words back to back
	task automatic rd(input logic [7:0] a, input logic [15:0] e0,
		input logic [15:0] e1);
		logic [15:0] q;
		logic b;
		u_sec_host.send({16'h0, 1'b1, OP_READ, a}, 11);
		u_sec_host.bit_(1'b0, b);
		check({oe, b}, 2'b10);
		for (int w = 0; w < 2; w++) begin
			for (int i = 0; i < 16; i++) begin
				u_sec_host.bit_(1'b0, b);
				q = {q[14:0], b};
			end
			check(q, w ? e1 : e0);
		end
		u_sec_host.drop();
		check(oe, 1'b0);
	endtask : rd
	task automatic t_lock();
		prog(OP_WRITE, 8'h05, 16'h1234, 1'b0);
	endtask : t_lock
	task automatic t_clear_all();
		prog(OP_SPECIAL, {SUB_ENABLE, 6'h0}, 16'h0, 1'b0);
		prog(OP_SPECIAL, {SUB_CLEAR, 6'h0}, 16'h0, 1'b1);
		rd(8'hff, 16'hffff, 16'hffff);
	endtask : t_clear_all
	task automatic t_write();
		prog(OP_WRITE, 8'h00, 16'ha5c3, 1'b1);
		prog(OP_WRITE, 8'h00, 16'h0f0f, 1'b1);
		prog(OP_WRITE, 8'hff, 16'h1234, 1'b1);
		// cut write: select falls mid data, nothing may start
		u_sec_host.send({12'h0, 1'b1, OP_WRITE, 8'hff, 4'h0}, 15);
		u_sec_host.drop();
		check(busy, 1'b0);
		rd(8'hff, 16'h1234, 16'h0f0f);
	endtask : t_write
	task automatic t_erase();
		prog(OP_ERASE, 8'h00, 16'h0, 1'b1);
		prog(OP_SPECIAL, {SUB_DISABLE, 6'h0}, 16'h0, 1'b0);
		prog(OP_ERASE, 8'hff, 16'h0, 1'b0);
		rd(8'hff, 16'h1234, 16'hffff);
	endtask : t_erase
	task automatic t_fill();
		prog(OP_SPECIAL, {SUB_ENABLE, 6'h0}, 16'h0, 1'b0);
		prog(OP_SPECIAL, {SUB_FILL, 6'h0}, 16'h5a5a, 1'b1);
		rd(8'h7f, 16'h5a5a, 16'h5a5a);
	endtask : t_fill
	// reset, then scenarios in order
	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		wt(4);
		t_lock();
		t_clear_all();
		t_write();
		t_erase();
		t_fill();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
